// file: hw/wrl_pkg.sv
package wrl_pkg;
	localparam logic [7:0] ADDR_BATT_TH = 8'h18;
	localparam logic [7:0] ADDR_MON = 8'h19;
	localparam logic [7:0] ADDR_RECT = 8'h1A;
	localparam logic [7:0] ADDR_TH1 = 8'h1B;
	localparam logic [7:0] ADDR_TH2 = 8'h1C;
	localparam logic [7:0] ADDR_TH3 = 8'h1D;
	localparam logic [7:0] ADDR_TH4 = 8'h1E;
	localparam logic [7:0] ADDR_HYS = 8'h1F;
	localparam logic [7:0] ADDR_SEND = 8'h20;
	localparam logic [7:0] ADDR_TX_HDR = 8'h21;
	localparam logic [7:0] ADDR_TX_M1 = 8'h22;
	localparam logic [7:0] ADDR_TX_M2 = 8'h23;
	localparam logic [7:0] ADDR_RX_HDR = 8'h24;
	localparam logic [7:0] ADDR_RX_M1 = 8'h25;
	localparam logic [7:0] ADDR_RX_M2 = 8'h26;
	localparam logic [7:0] ADDR_RATE = 8'h27;
	localparam logic [7:0] ADDR_DEMOD_TH = 8'h28;
	localparam logic [7:0] ADDR_FLAGS = 8'h30;
	localparam logic [7:0] RST_BATT_TH = 8'h20;
	localparam logic [7:0] RST_TH1 = 8'h0B;
	localparam logic [7:0] RST_TH2 = 8'h17;
	localparam logic [7:0] RST_TH3 = 8'h2E;
	localparam logic [7:0] RST_TH4 = 8'h5B;
	localparam logic [6:0] RST_HYS = 7'h0B;
	localparam logic [1:0] RST_RATE = 2'h1;
	localparam logic [1:0] RST_REF_SAMPLE = 2'h3;
	localparam logic [3:0] RST_ACQ_DELAY = 4'h3;
	localparam logic [7:0] RST_DEMOD_TH = 8'h00;
	localparam int POS_FORCE = 3;
	localparam int POS_FULL_SYNC = 2;
	localparam int POS_APPLY = 7;
	localparam int POS_APPLIED_SYNC = 6;
	localparam int POS_PHASE = 4;
	localparam int POS_RATE = 0;
	localparam int POS_REF = 2;
	localparam int POS_ACQ = 4;

	typedef enum logic [2:0]
	{
		TX_IDLE = 3'b001,
		TX_START = 3'b010,
		TX_BUSY = 3'b100
	} wrl_tx_state_t;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wrl_bus_t;

	typedef struct packed
	{
		logic valid;
		logic [7:0] hdr;
		logic [7:0] m1;
		logic [7:0] m2;
	} wrl_packet_t;

	typedef struct packed
	{
		logic [7:0] batt_th;
		logic [1:0] on_res_set;
		logic full_sync;
		logic force_on;
		logic [1:0] applied_res;
		logic applied_sync;
		logic [7:0] th_stage1;
		logic [7:0] th_stage2;
		logic [7:0] th_stage3;
		logic [7:0] th_stage4;
		logic [6:0] hys_stage;
		logic apply;
		logic [8:0] dec1;
		logic [8:0] dec2;
		logic [8:0] dec3;
		logic [8:0] dec4;
		logic [8:0] hys;
		logic send;
		wrl_tx_state_t tx_state;
		logic [7:0] tx_hdr;
		logic [7:0] tx_m1;
		logic [7:0] tx_m2;
		logic [7:0] rx_hdr;
		logic [7:0] rx_m1;
		logic [7:0] rx_m2;
		logic [1:0] rate;
		logic [1:0] ref_sample;
		logic [3:0] acq_delay;
		logic [7:0] demod_th;
		logic rx_flag;
		logic [7:0] rdata;
		logic tx_start;
		logic [1:0] auto_pins_meta;
		logic [1:0] auto_pins;
	} wrl_state_t;
endpackage

// file: hw/wrl_regs.sv
`timescale 1ns/1ps
// Contract
// R1: Battery difference threshold, 8 bit, reset 32
// R2: Read-only detected monitor resistor code
// R3: Read-only power transfer phase at 0x19[5:4]
// R4: On-resistance setting used only when forced
// R5: Full-sync enable honoured only when forced
// R6: Force bit selects register on-resistance
// R7: Applied resistance and sync mode readable
// R8: Current thresholds are 9-bit comparison codes
// R9: Decreasing thresholds reset 11, 23, 46, 91
// R10: Increasing threshold is decreasing plus hysteresis
// R11: Apply bit loads thresholds, then self-clears
// R12: Thresholds steer rectifier only when pins high
// R13: Send trigger self-clears when transmission completes
// R14: Transmit header and messages, read/write, reset zero
// R15: Received bytes overwritten on each reception
// R16: Link bit rate field, reset 250 bps
// R17: Demod reference sample field, reset 3
// R18: Demod acquire delay field, reset 3
// R19: Demod variation threshold at 0x28
// R20: Packet received flag clears on flag read
// R21: Unassigned bits read zero, writes ignored
module wrl_regs
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CE,
	input wire wrl_pkg::wrl_bus_t BUS,
	output logic [7:0] RDATA,
	input wire logic [1:0] MONITOR_RESISTOR_CODE,
	input wire logic [1:0] POWER_TRANSFER_PHASE,
	input wire logic AUTO_POWER_CONTROL_PIN,
	input wire logic RECTIFIER_AUTO_PIN,
	input wire logic [1:0] AUTO_ON_RESISTANCE,
	input wire logic AUTO_SYNC_MODE,
	input wire logic [8:0] CURRENT_MONITOR_CODE,
	input wire wrl_pkg::wrl_packet_t RX_PACKET,
	input wire logic TX_DONE,
	output logic TX_START,
	output logic [7:0] TX_HEADER,
	output logic [7:0] TX_MSG_ONE,
	output logic [7:0] TX_MSG_TWO,
	output logic [1:0] LINK_BIT_RATE,
	output logic [1:0] DEMOD_REFERENCE_SAMPLE,
	output logic [3:0] DEMOD_ACQUIRE_DELAY,
	output logic [7:0] DEMOD_VARIATION_THRESHOLD,
	output logic [7:0] BATTERY_DIFF_THRESHOLD,
	output logic [1:0] APPLIED_ON_RESISTANCE,
	output logic APPLIED_SYNC_MODE,
	output logic PACKET_RECEIVED_FLAG
);
	wrl_pkg::wrl_state_t s_reg;
	wrl_pkg::wrl_state_t s_next;
	logic [1:0] auto_step;

	// Widen an 8-bit threshold byte to the 9-bit compare scale
	function automatic logic [8:0] widen(input logic [7:0] v);
		widen = {1'b0, v};
	endfunction

	// Rectifier step from load current with hysteresis on rising current
	function automatic logic [1:0] step_of(
		input logic [8:0] cur,
		input logic [1:0] prev,
		input logic [8:0] d1,
		input logic [8:0] d2,
		input logic [8:0] d3,
		input logic [8:0] d4,
		input logic [8:0] h);
		logic [1:0] r;
		logic [9:0] up;
		r = prev;
		up = {1'b0, d1} + {1'b0, h}; // R10
		if (prev == 2'h0 && {1'b0, cur} > up)
		begin
			r = 2'h1;
		end
		up = {1'b0, d2} + {1'b0, h}; // R10
		if (prev == 2'h1 && {1'b0, cur} > up)
		begin
			r = 2'h2;
		end
		up = {1'b0, d3} + {1'b0, h}; // R10
		if (prev == 2'h2 && {1'b0, cur} > up)
		begin
			r = 2'h3;
		end
		if (prev == 2'h1 && cur < d1)
		begin
			r = 2'h0;
		end
		if (prev == 2'h2 && cur < d2)
		begin
			r = 2'h1;
		end
		if (prev == 2'h3 && cur < d3)
		begin
			r = 2'h2;
		end
		if (cur < d4)
		begin
			r = r;
		end
		step_of = r;
	endfunction

	always_comb
	begin
		s_next = s_reg;
		s_next.tx_start = 1'b0;
		s_next.auto_pins_meta = {AUTO_POWER_CONTROL_PIN, RECTIFIER_AUTO_PIN};
		s_next.auto_pins = s_reg.auto_pins_meta;
		auto_step = step_of(CURRENT_MONITOR_CODE, s_reg.applied_res, // R8
			s_reg.dec1, s_reg.dec2, s_reg.dec3, s_reg.dec4, s_reg.hys);
		// Applied rectifier setting
		if (s_reg.force_on)
		begin
			s_next.applied_res = s_reg.on_res_set; // R4 R6
			s_next.applied_sync = s_reg.full_sync; // R5
		end
		else if (s_reg.auto_pins == 2'b11)
		begin
			s_next.applied_res = auto_step; // R12
			s_next.applied_sync = AUTO_SYNC_MODE;
		end
		else
		begin
			s_next.applied_res = AUTO_ON_RESISTANCE;
			s_next.applied_sync = AUTO_SYNC_MODE;
		end
		// Staged thresholds take effect one cycle after the apply write
		if (s_reg.apply)
		begin
			s_next.dec1 = widen(s_reg.th_stage1); // R11
			s_next.dec2 = widen(s_reg.th_stage2);
			s_next.dec3 = widen(s_reg.th_stage3);
			s_next.dec4 = widen(s_reg.th_stage4);
			s_next.hys = {2'h0, s_reg.hys_stage};
			s_next.apply = 1'b0; // R11
		end
		// Transmit sequencing
		case (s_reg.tx_state)
			wrl_pkg::TX_IDLE:
			begin
				if (s_reg.send)
				begin
					s_next.tx_state = wrl_pkg::TX_START;
				end
			end
			wrl_pkg::TX_START:
			begin
				s_next.tx_start = 1'b1;
				s_next.tx_state = wrl_pkg::TX_BUSY;
			end
			wrl_pkg::TX_BUSY:
			begin
				if (TX_DONE)
				begin
					s_next.send = 1'b0; // R13
					s_next.tx_state = wrl_pkg::TX_IDLE;
				end
			end
			default:
			begin
				s_next.tx_state = wrl_pkg::TX_IDLE;
			end
		endcase
		// Read mux, unassigned bits return zero
		s_next.rdata = 8'h00; // R21
		if (BUS.rd)
		begin
			case (BUS.addr)
				wrl_pkg::ADDR_BATT_TH: s_next.rdata = s_reg.batt_th;
				wrl_pkg::ADDR_MON: s_next.rdata = {2'h0, // R2 R3
					POWER_TRANSFER_PHASE, 2'h0, MONITOR_RESISTOR_CODE};
				wrl_pkg::ADDR_RECT: s_next.rdata = {1'b0, // R7
					s_reg.applied_sync, s_reg.applied_res,
					s_reg.force_on, s_reg.full_sync, s_reg.on_res_set};
				wrl_pkg::ADDR_TH1: s_next.rdata = s_reg.th_stage1;
				wrl_pkg::ADDR_TH2: s_next.rdata = s_reg.th_stage2;
				wrl_pkg::ADDR_TH3: s_next.rdata = s_reg.th_stage3;
				wrl_pkg::ADDR_TH4: s_next.rdata = s_reg.th_stage4;
				wrl_pkg::ADDR_HYS: s_next.rdata = {s_reg.apply,
					s_reg.hys_stage};
				wrl_pkg::ADDR_SEND: s_next.rdata = {7'h00, s_reg.send};
				wrl_pkg::ADDR_TX_HDR: s_next.rdata = s_reg.tx_hdr;
				wrl_pkg::ADDR_TX_M1: s_next.rdata = s_reg.tx_m1;
				wrl_pkg::ADDR_TX_M2: s_next.rdata = s_reg.tx_m2;
				wrl_pkg::ADDR_RX_HDR: s_next.rdata = s_reg.rx_hdr;
				wrl_pkg::ADDR_RX_M1: s_next.rdata = s_reg.rx_m1;
				wrl_pkg::ADDR_RX_M2: s_next.rdata = s_reg.rx_m2;
				wrl_pkg::ADDR_RATE: s_next.rdata = {s_reg.acq_delay,
					s_reg.ref_sample, s_reg.rate};
				wrl_pkg::ADDR_DEMOD_TH: s_next.rdata = s_reg.demod_th;
				wrl_pkg::ADDR_FLAGS:
				begin
					s_next.rdata = {7'h00, s_reg.rx_flag};
					s_next.rx_flag = 1'b0; // R20
				end
				default: s_next.rdata = 8'h00;
			endcase
		end
		if (BUS.wr)
		begin
			case (BUS.addr)
				wrl_pkg::ADDR_BATT_TH: s_next.batt_th = BUS.wdata; // R1
				wrl_pkg::ADDR_RECT:
				begin
					s_next.on_res_set = BUS.wdata[1:0]; // R4
					s_next.full_sync = BUS.wdata[wrl_pkg::POS_FULL_SYNC];
					s_next.force_on = BUS.wdata[wrl_pkg::POS_FORCE]; // R6
				end
				wrl_pkg::ADDR_TH1: s_next.th_stage1 = BUS.wdata; // R9
				wrl_pkg::ADDR_TH2: s_next.th_stage2 = BUS.wdata;
				wrl_pkg::ADDR_TH3: s_next.th_stage3 = BUS.wdata;
				wrl_pkg::ADDR_TH4: s_next.th_stage4 = BUS.wdata;
				wrl_pkg::ADDR_HYS:
				begin
					s_next.hys_stage = BUS.wdata[6:0]; // R10
					s_next.apply = BUS.wdata[wrl_pkg::POS_APPLY]; // R11
				end
				wrl_pkg::ADDR_SEND:
				begin
					if (BUS.wdata[0])
					begin
						s_next.send = 1'b1; // R13
					end
				end
				wrl_pkg::ADDR_TX_HDR: s_next.tx_hdr = BUS.wdata; // R14
				wrl_pkg::ADDR_TX_M1: s_next.tx_m1 = BUS.wdata;
				wrl_pkg::ADDR_TX_M2: s_next.tx_m2 = BUS.wdata;
				wrl_pkg::ADDR_RATE:
				begin
					s_next.rate = BUS.wdata[1:0]; // R16
					s_next.ref_sample = BUS.wdata[3:2]; // R17
					s_next.acq_delay = BUS.wdata[7:4]; // R18
				end
				wrl_pkg::ADDR_DEMOD_TH: s_next.demod_th = BUS.wdata; // R19
				default:
				begin
				end
			endcase
		end
		// Reception overwrites unread bytes; set wins over the read clear
		if (RX_PACKET.valid)
		begin
			s_next.rx_hdr = RX_PACKET.hdr; // R15
			s_next.rx_m1 = RX_PACKET.m1;
			s_next.rx_m2 = RX_PACKET.m2;
			s_next.rx_flag = 1'b1; // R20
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			s_reg <= '0;
			s_reg.batt_th <= wrl_pkg::RST_BATT_TH; // R1
			s_reg.th_stage1 <= wrl_pkg::RST_TH1; // R9
			s_reg.th_stage2 <= wrl_pkg::RST_TH2;
			s_reg.th_stage3 <= wrl_pkg::RST_TH3;
			s_reg.th_stage4 <= wrl_pkg::RST_TH4;
			s_reg.hys_stage <= wrl_pkg::RST_HYS; // R10
			s_reg.dec1 <= {1'b0, wrl_pkg::RST_TH1};
			s_reg.dec2 <= {1'b0, wrl_pkg::RST_TH2};
			s_reg.dec3 <= {1'b0, wrl_pkg::RST_TH3};
			s_reg.dec4 <= {1'b0, wrl_pkg::RST_TH4};
			s_reg.hys <= {2'h0, wrl_pkg::RST_HYS};
			s_reg.tx_state <= wrl_pkg::TX_IDLE;
			s_reg.rate <= wrl_pkg::RST_RATE; // R16
			s_reg.ref_sample <= wrl_pkg::RST_REF_SAMPLE; // R17
			s_reg.acq_delay <= wrl_pkg::RST_ACQ_DELAY; // R18
			s_reg.demod_th <= wrl_pkg::RST_DEMOD_TH;
		end
		else if (CE)
		begin
			s_reg <= s_next;
		end
	end

	assign RDATA = s_reg.rdata;
	assign TX_START = s_reg.tx_start;
	assign TX_HEADER = s_reg.tx_hdr;
	assign TX_MSG_ONE = s_reg.tx_m1;
	assign TX_MSG_TWO = s_reg.tx_m2;
	assign LINK_BIT_RATE = s_reg.rate;
	assign DEMOD_REFERENCE_SAMPLE = s_reg.ref_sample;
	assign DEMOD_ACQUIRE_DELAY = s_reg.acq_delay;
	assign DEMOD_VARIATION_THRESHOLD = s_reg.demod_th;
	assign BATTERY_DIFF_THRESHOLD = s_reg.batt_th;
	assign APPLIED_ON_RESISTANCE = s_reg.applied_res;
	assign APPLIED_SYNC_MODE = s_reg.applied_sync;
	assign PACKET_RECEIVED_FLAG = s_reg.rx_flag;
endmodule // wrl_regs

// file: tb/wrl_regs_props.sv
`timescale 1ns/1ps
module wrl_regs_props
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CE,
	input wire wrl_pkg::wrl_bus_t BUS,
	input wire logic [7:0] RDATA,
	input wire logic [1:0] MONITOR_RESISTOR_CODE,
	input wire logic [1:0] POWER_TRANSFER_PHASE,
	input wire logic RECTIFIER_AUTO_PIN,
	input wire logic [1:0] AUTO_ON_RESISTANCE,
	input wire logic AUTO_SYNC_MODE,
	input wire wrl_pkg::wrl_packet_t RX_PACKET,
	input wire logic TX_START,
	input wire logic [7:0] TX_HEADER,
	input wire logic [7:0] TX_MSG_ONE,
	input wire logic [7:0] TX_MSG_TWO,
	input wire logic [1:0] LINK_BIT_RATE,
	input wire logic [1:0] DEMOD_REFERENCE_SAMPLE,
	input wire logic [3:0] DEMOD_ACQUIRE_DELAY,
	input wire logic [7:0] DEMOD_VARIATION_THRESHOLD,
	input wire logic [7:0] BATTERY_DIFF_THRESHOLD,
	input wire logic [1:0] APPLIED_ON_RESISTANCE,
	input wire logic APPLIED_SYNC_MODE,
	input wire logic PACKET_RECEIVED_FLAG
);
	logic [3:0] rect_reg;
	wire wr_en = CE && BUS.wr;
	wire rd_en = CE && BUS.rd;
	// Shadow of the rectifier control bits written by the host
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			rect_reg <= 4'h0;
		else if (wr_en && BUS.addr == 8'h1A)
			rect_reg <= BUS.wdata[3:0];
	end
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	a_batt_write:
	assert property (wr_en && BUS.addr == 8'h18 |=>
		BATTERY_DIFF_THRESHOLD == $past(BUS.wdata)) else $error("batt");
	a_mon_read:
	assert property (rd_en && BUS.addr == 8'h19 |=> RDATA == {2'h0,
		$past(POWER_TRANSFER_PHASE), 2'h0, $past(MONITOR_RESISTOR_CODE)})
		else $error("monitor read");
	a_link_fields:
	assert property (wr_en && BUS.addr == 8'h27 |=> {DEMOD_ACQUIRE_DELAY,
		DEMOD_REFERENCE_SAMPLE, LINK_BIT_RATE} == $past(BUS.wdata))
		else $error("link fields");
	a_forced_rect:
	assert property (rect_reg[3] && $past(rect_reg) == rect_reg |->
		{APPLIED_SYNC_MODE, APPLIED_ON_RESISTANCE} == rect_reg[2:0])
		else $error("forced rectifier");
	a_auto_pass:
	assert property ((CE && !rect_reg[3] && !RECTIFIER_AUTO_PIN &&
		$stable({AUTO_SYNC_MODE, AUTO_ON_RESISTANCE})) [*5] |->
		APPLIED_ON_RESISTANCE == AUTO_ON_RESISTANCE &&
		APPLIED_SYNC_MODE == AUTO_SYNC_MODE) else $error("auto pass");
	a_flag_set:
	assert property (CE && RX_PACKET.valid |=> PACKET_RECEIVED_FLAG)
		else $error("flag set");
	a_flag_clear:
	assert property (rd_en && BUS.addr == 8'h30 && !RX_PACKET.valid |=>
		!PACKET_RECEIVED_FLAG) else $error("flag clear");
	a_start_pulse:
	assert property (TX_START |=> !TX_START) else $error("start pulse");
	a_tx_header:
	assert property (wr_en && BUS.addr == 8'h21 |=>
		TX_HEADER == $past(BUS.wdata)) else $error("tx header");
	a_tx_msg_one:
	assert property (wr_en && BUS.addr == 8'h22 |=>
		TX_MSG_ONE == $past(BUS.wdata)) else $error("tx message one");
	a_tx_msg_two:
	assert property (wr_en && BUS.addr == 8'h23 |=>
		TX_MSG_TWO == $past(BUS.wdata)) else $error("tx message two");
	a_demod_threshold:
	assert property (wr_en && BUS.addr == 8'h28 |=>
		DEMOD_VARIATION_THRESHOLD == $past(BUS.wdata))
		else $error("demod threshold");
endmodule // wrl_regs_props

bind wrl_regs wrl_regs_props wrl_regs_props_inst
(
	.CLK_SYS(CLK_SYS),
	.RST(RST),
	.CE(CE),
	.BUS(BUS),
	.RDATA(RDATA),
	.MONITOR_RESISTOR_CODE(MONITOR_RESISTOR_CODE),
	.POWER_TRANSFER_PHASE(POWER_TRANSFER_PHASE),
	.RECTIFIER_AUTO_PIN(RECTIFIER_AUTO_PIN),
	.AUTO_ON_RESISTANCE(AUTO_ON_RESISTANCE),
	.AUTO_SYNC_MODE(AUTO_SYNC_MODE),
	.RX_PACKET(RX_PACKET),
	.TX_START(TX_START),
	.TX_HEADER(TX_HEADER),
	.TX_MSG_ONE(TX_MSG_ONE),
	.TX_MSG_TWO(TX_MSG_TWO),
	.LINK_BIT_RATE(LINK_BIT_RATE),
	.DEMOD_REFERENCE_SAMPLE(DEMOD_REFERENCE_SAMPLE),
	.DEMOD_ACQUIRE_DELAY(DEMOD_ACQUIRE_DELAY),
	.DEMOD_VARIATION_THRESHOLD(DEMOD_VARIATION_THRESHOLD),
	.BATTERY_DIFF_THRESHOLD(BATTERY_DIFF_THRESHOLD),
	.APPLIED_ON_RESISTANCE(APPLIED_ON_RESISTANCE),
	.APPLIED_SYNC_MODE(APPLIED_SYNC_MODE),
	.PACKET_RECEIVED_FLAG(PACKET_RECEIVED_FLAG)
);

// file: tb/wrl_far_end.sv
`timescale 1ns/1ps
module wrl_far_end
#(
	parameter int DONE_DELAY = 20
)
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic TX_START,
	input wire logic RX_GO,
	input wire logic [23:0] RX_BYTES,
	output logic TX_DONE,
	output wrl_pkg::wrl_packet_t RX_PACKET
);
	int cnt_reg;
	logic vld_reg;
	logic [23:0] dat_reg;
	// Bytes show the inverse of the last packet outside the valid pulse
	assign RX_PACKET = {vld_reg, vld_reg ? dat_reg : ~dat_reg};
	always_ff @(posedge CLK_SYS)
	begin
		vld_reg <= RX_GO;
		if (RX_GO || RST)
			dat_reg <= RX_BYTES;
		if (RST)
			cnt_reg <= 0;
		else if (TX_START)
			cnt_reg <= DONE_DELAY;
		else if (cnt_reg != 0)
			cnt_reg <= cnt_reg - 1;
		TX_DONE <= cnt_reg == 1;
	end
endmodule // wrl_far_end

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam logic [15:0] RT [17] = '{16'h1820, 16'h1A00, 16'h1B0B,
		16'h1C17, 16'h1D2E, 16'h1E5B, 16'h1F0B, 16'h2000, 16'h2100,
		16'h2200, 16'h2300, 16'h2400, 16'h2500, 16'h2600, 16'h273D,
		16'h2800, 16'h3000};
	localparam logic [7:0] RW [10] = '{8'h18, 8'h1B, 8'h1C, 8'h1D, 8'h1E,
		8'h21, 8'h22, 8'h23, 8'h27, 8'h28};
	logic CLK_SYS = 0, RST = 1, CE = 1, rd_q = 0;
	wrl_pkg::wrl_bus_t bus = '0;
	wrl_pkg::wrl_packet_t rx_pkt;
	logic [1:0] res_code = 0, phase = 0, auto_res = 0;
	logic auto_sync = 0, apc_pin = 0, ra_pin = 0, rx_go = 0, tx_start;
	logic tx_done;
	logic [8:0] cur = 0;
	logic [23:0] rx_bytes = 0;
	logic [7:0] rdata, v;
	logic [15:0] ent, expq[$];
	int n_fail = 0, tests_run = 0, cyc = 0, i;
	always #2.5 CLK_SYS = ~CLK_SYS;
	wrl_regs wrl_regs_inst (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE),
		.BUS(bus), .RDATA(rdata), .MONITOR_RESISTOR_CODE(res_code),
		.POWER_TRANSFER_PHASE(phase), .AUTO_POWER_CONTROL_PIN(apc_pin),
		.RECTIFIER_AUTO_PIN(ra_pin), .AUTO_ON_RESISTANCE(auto_res),
		.AUTO_SYNC_MODE(auto_sync), .CURRENT_MONITOR_CODE(cur),
		.RX_PACKET(rx_pkt), .TX_DONE(tx_done), .TX_START(tx_start),
		.TX_HEADER(), .TX_MSG_ONE(), .TX_MSG_TWO(), .LINK_BIT_RATE(),
		.DEMOD_REFERENCE_SAMPLE(), .DEMOD_ACQUIRE_DELAY(),
		.DEMOD_VARIATION_THRESHOLD(), .BATTERY_DIFF_THRESHOLD(),
		.APPLIED_ON_RESISTANCE(), .APPLIED_SYNC_MODE(),
		.PACKET_RECEIVED_FLAG());
	wrl_far_end wrl_far_end_inst (.CLK_SYS(CLK_SYS), .RST(RST),
		.TX_START(tx_start), .RX_GO(rx_go), .RX_BYTES(rx_bytes),
		.TX_DONE(tx_done), .RX_PACKET(rx_pkt));
	task automatic chk(input logic [7:0] a, s, e);
		tests_run++;
		if (s !== e)
		begin
			n_fail++;
			$display("MISMATCH reg %h expected %h seen %h", a, e, s);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(posedge CLK_SYS);
		#1 bus = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge CLK_SYS);
		#1 bus = '0;
	endtask
	// Reads queue their expectation; the monitor below compares
	task automatic rd(input logic [7:0] a, e);
		expq.push_back({a, e});
		acc(0, a, 8'h00);
	endtask
	always @(posedge CLK_SYS)
	begin
		rd_q <= bus.rd && CE && !RST;
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	always @(negedge CLK_SYS)
	begin
		if (rd_q)
		begin
			ent = expq.size() ? expq.pop_front() : 16'hFFFF;
			chk(ent[15:8], rdata, ent[7:0]);
		end
	end
	initial
	begin
		void'($urandom(32'hc562));
		repeat (12) @(posedge CLK_SYS);
		#1 RST = 0;
		foreach (RT[k])
			rd(RT[k][15:8], RT[k][7:0]);
		$display("test reset done");
		for (i = 0; i < 4; i++)
		begin
			res_code = 2'(i);
			phase = 2'($urandom);
			rd(8'h19, {2'h0, phase, 2'h0, res_code});
		end
		foreach (RW[k])
		begin
			v = 8'($urandom);
			acc(1, RW[k], v);
			rd(RW[k], v);
		end
		// A write while the clock enable is low must not land
		acc(1, 8'h18, 8'h5A);
		CE = 0;
		acc(1, 8'h18, 8'hA5);
		CE = 1;
		rd(8'h18, 8'h5A);
		acc(1, 8'h24, 8'hFF);
		rd(8'h24, 8'h00);
		rd(8'h40, 8'h00);
		$display("test access done");
		apc_pin = 1;
		ra_pin = 1;
		for (i = 0; i < 8; i++)
		begin
			auto_res = 2'($urandom);
			cur = 9'($urandom);
			v = {5'h01, 3'(i)};
			acc(1, 8'h1A, v | 8'hF0);
			rd(8'h1A, {1'b0, v[2:0], v[3:0]});
		end
		acc(1, 8'h1A, 8'h00);
		ra_pin = 0;
		auto_res = 2'($urandom);
		auto_sync = 1'($urandom);
		repeat (8) @(posedge CLK_SYS);
		rd(8'h1A, {1'b0, auto_sync, auto_res, 4'h0});
		v = 8'($urandom) & 8'h7F;
		acc(1, 8'h1F, v | 8'h80);
		rd(8'h1F, v);
		// Known thresholds 0x40/0x80/0xC0/0xF0, hysteresis 0x10, applied
		acc(1, 8'h1B, 8'h40);
		acc(1, 8'h1C, 8'h80);
		acc(1, 8'h1D, 8'hC0);
		acc(1, 8'h1E, 8'hF0);
		acc(1, 8'h1F, 8'h90);
		cur = 9'h000;
		ra_pin = 1;
		repeat (8) @(posedge CLK_SYS);
		rd(8'h1A, {1'b0, auto_sync, 2'h0, 4'h0});
		cur = 9'h050;
		repeat (4) @(posedge CLK_SYS);
		rd(8'h1A, {1'b0, auto_sync, 2'h0, 4'h0});
		cur = 9'h051;
		repeat (4) @(posedge CLK_SYS);
		rd(8'h1A, {1'b0, auto_sync, 2'h1, 4'h0});
		cur = 9'h1FF;
		repeat (4) @(posedge CLK_SYS);
		rd(8'h1A, {1'b0, auto_sync, 2'h3, 4'h0});
		cur = 9'h03F;
		repeat (4) @(posedge CLK_SYS);
		rd(8'h1A, {1'b0, auto_sync, 2'h0, 4'h0});
		ra_pin = 0;
		$display("test rectifier done");
		acc(1, 8'h20, 8'hFF);
		rd(8'h20, 8'h01);
		for (i = 0; i < 100 && !tx_done; i++)
		begin
			@(posedge CLK_SYS);
			#1;
		end
		chk(8'h20, 8'(i < 100), 8'h01);
		repeat (2) @(posedge CLK_SYS);
		rd(8'h20, 8'h00);
		for (i = 0; i < 2; i++)
		begin
			rx_bytes = 24'($urandom);
			rx_go = 1;
			@(posedge CLK_SYS);
			#1 rx_go = 0;
			rd(8'h24, rx_bytes[23:16]);
			rd(8'h25, rx_bytes[15:8]);
			rd(8'h26, rx_bytes[7:0]);
			rd(8'h30, 8'h01);
			rd(8'h30, 8'h00);
		end
		$display("test link done");
		// Reset again in mid-run and check every reset value once more
		auto_res = 2'h0;
		auto_sync = 1'b0;
		cur = 9'h000;
		RST = 1;
		repeat (3) @(posedge CLK_SYS);
		#1 RST = 0;
		foreach (RT[k])
			rd(RT[k][15:8], RT[k][7:0]);
		$display("test second reset done");
		repeat (3) @(posedge CLK_SYS);
		report_and_stop();
	end
endmodule // tb_top
